// File: src/hbs_pkg.sv
// Shared constants and types of the host bus share bridge.
// Assumes one 20 MHz system clock and jumper straps held static.
package hbs_pkg;

    ////////////////////////////////////////////////////////////////
    // Clocking
    localparam int CLK_SYS_HZ = 20000000;
    localparam int OSC_HZ = 4915200;
    localparam int SYS_CLK_DIV = 2;

    ////////////////////////////////////////////////////////////////
    // Port addresses
    localparam logic [3:0] HOST_STATUS_PORT_HI = 4'hf;
    localparam logic [7:0] LOCAL_STATUS_PORT = 8'h0f;
    localparam logic [7:0] BAUD_PORT_12 = 8'h0d;
    localparam logic [7:0] BAUD_PORT_34 = 8'h0e;
    localparam logic [3:0] LOCAL_PORT_HI = 4'h0;

    ////////////////////////////////////////////////////////////////
    // Memory sizes, as byte and word counts inside a 4K block
    localparam int ROM0_SMALL_BYTES = 2048;
    localparam int ROM0_LARGE_BYTES = 4096;
    localparam int SOCK1_SMALL_BYTES = 1024;
    localparam int SOCK1_LARGE_BYTES = 2048;
    localparam int RAM_WORDS = 1024;
    localparam int RAM_WIDTH = 8;

    ////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    localparam logic [7:0] DIN_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_XFER = 2'b10,
        ST_HOLD = 2'b11
    } hbs_state_t;

    typedef struct packed {
        hbs_state_t st;
        logic is_io;
        logic is_wr;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] din;
        logic [7:0] status;
        logic [15:0] baud;
        logic hint;
        logic nmi;
        logic osc_prev;
        logic cpu_clk;
        logic cpu_int;
    } hbs_regs_t;

endpackage

// File: src/hbs_sync.sv
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; words are not kept coherent.
`timescale 1ns/1ns
module hbs_sync
#(
    parameter int W = 1
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hbs_sync_t;

    hbs_sync_t r_q;
    hbs_sync_t r_d;

    always_comb
    begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule

// File: src/hbs_bridge.sv
// Host bus share bridge: board select, bus hand-over, wait state,
// memory and port decode, status port and interrupts.
// Assumes the local processor logic runs on clk_sys; host pins, straps,
// grant and oscillator arrive asynchronously and are synchronised.
//
// Behaviour
// - Oscillator passes undivided to the baud rate generators.
// - Local processor clock is the oscillator divided by two.
// - With interrupt jumper fitted, host status write raises host interrupt.
// - Host read of status port removes the pending host interrupt.
// - Host write to port F-nibble plus board number pulses local NMI.
// - Board select raises bus request and enables host address buffer.
// - Host waits from selection until local bus grant returns.
// - Granting processor floats its lines; host never co-drives local bus.
// - Multiplexer routes host signals when host owns board, else local.
// - Memory enables follow configured socket and RAM sizes and bases.
// - Socket 0 ROM 2K/4K; socket 1 ROM or RAM 1K/2K by option.
// - Board holds a 1K by 8 static RAM.
// - Port decoder gives one select per local I/O port.
// - Host write data enters via input buffer; read data leaves via output.
// - Serial transceivers interrupt local processor on received character.
// - Timer channel 0 is tick; channels 1 to 3 go to user header.
// - Each channel gets a baud code written by the local processor.
// - Host address, data out, strobes, clear in; data in, ready, vectors out.
// - Bus grant selects mux, enables data buffers; selection enables address buffer.
// - Host write never changes the stored status byte.
// - Local processor reaches the status port at 0FH.
`timescale 1ns/1ns
module hbs_bridge
    import hbs_pkg::*;
#(
    parameter int RAM_DEPTH = RAM_WORDS
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [15:0] host_addr,
    input wire logic [7:0] host_dout,
    input wire logic host_sout,
    input wire logic host_sinp,
    input wire logic host_memr,
    input wire logic host_memw,
    input wire logic host_poc,
    output logic [7:0] host_din,
    output logic host_prdy,
    output logic [3:0] host_vi,
    output logic host_addr_buf_en,
    output logic host_din_buf_en,
    output logic host_dout_buf_en,
    input wire logic [3:0] board_num,
    input wire logic [3:0] host_win_base,
    input wire logic hint_enable,
    input wire logic [1:0] hint_line,
    input wire logic [3:0] rom0_base,
    input wire logic rom0_is_4k,
    input wire logic [3:0] sock1_base,
    input wire logic sock1_is_2k,
    input wire logic sock1_is_ram,
    input wire logic [3:0] ram_base,
    input wire logic osc_in,
    input wire logic local_bus_grant,
    input wire logic [3:0] serial_rx_irq,
    input wire logic [3:0] counter_timer_ch,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_memrd,
    input wire logic cpu_memwr,
    input wire logic cpu_iord,
    input wire logic cpu_iowr,
    output logic [7:0] cpu_rdata,
    input wire logic [7:0] ext_rdata,
    output logic local_bus_request,
    output logic local_nmi,
    output logic local_int,
    output logic cpu_clk,
    output logic baud_rate_generator_clk,
    output logic [15:0] baud_code,
    output logic [2:0] user_timer_header,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_memrd,
    output logic bus_memwr,
    output logic bus_iord,
    output logic bus_iowr,
    output logic rom0_sel,
    output logic sock1_sel,
    output logic sock1_we,
    output logic ram_sel,
    output logic [15:0] port_sel
);
    localparam int RAM_AW = $clog2(RAM_DEPTH);

    ////////////////////////////////////////////////////////////////
    // Synchronisers
    logic [28:0] hsync;
    logic [35:0] lsync;
    logic [15:0] h_addr_s;
    logic [7:0] h_dout_s;
    logic h_sout_s, h_sinp_s, h_memr_s, h_memw_s, poc_s;
    logic osc_s, grant_s;
    logic [3:0] rx_s, tmr_s, brd_s, win_s, rom0_b_s, sock1_b_s, ram_b_s;
    logic hint_en_s, rom0_4k_s, sock1_2k_s, sock1_ram_s;
    logic [1:0] hint_line_s;

    hbs_sync #(.W(29)) u_host_sync
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .d({host_poc, host_memw, host_memr, host_sinp, host_sout,
            host_dout, host_addr}),
        .q(hsync)
    );

    hbs_sync #(.W(36)) u_local_sync
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .d({osc_in, local_bus_grant, serial_rx_irq, counter_timer_ch,
            board_num, host_win_base, hint_enable, hint_line, rom0_base,
            rom0_is_4k, sock1_base, sock1_is_2k, sock1_is_ram, ram_base}),
        .q(lsync)
    );

    assign {poc_s, h_memw_s, h_memr_s, h_sinp_s, h_sout_s} = hsync[28:24];
    assign h_dout_s = hsync[23:16];
    assign h_addr_s = hsync[15:0];
    assign {osc_s, grant_s, rx_s, tmr_s, brd_s, win_s} = lsync[35:18];
    assign {hint_en_s, hint_line_s, rom0_b_s, rom0_4k_s} = lsync[17:10];
    assign {sock1_b_s, sock1_2k_s, sock1_ram_s, ram_b_s} = lsync[9:0];

    ////////////////////////////////////////////////////////////////
    // Host hit detection
    hbs_regs_t r_q;
    hbs_regs_t r_d;
    logic clr;
    logic h_io, h_strobe, h_stat_hit, h_mem_hit, h_hit;

    // Power-on clear acts as a second synchronous reset
    assign clr = reset | poc_s;
    assign h_io = h_sout_s | h_sinp_s;
    assign h_strobe = h_io | h_memr_s | h_memw_s;
    assign h_stat_hit = h_addr_s[7:0] == {HOST_STATUS_PORT_HI, brd_s};
    assign h_mem_hit = (h_memr_s | h_memw_s) & (h_addr_s[15:12] == win_s);
    assign h_hit = (h_io & h_stat_hit) | h_mem_hit;

    ////////////////////////////////////////////////////////////////
    // Bus multiplexer
    logic host_owns, xfer;
    logic [7:0] bus_rdata;

    assign host_owns = grant_s;
    assign xfer = r_q.st == ST_XFER;

    always_comb
    begin
        if (host_owns)
        begin
            bus_addr = r_q.addr;
            bus_wdata = r_q.wdata;
            bus_memrd = xfer & ~r_q.is_io & ~r_q.is_wr;
            bus_memwr = xfer & ~r_q.is_io & r_q.is_wr;
            bus_iord = xfer & r_q.is_io & ~r_q.is_wr;
            bus_iowr = xfer & r_q.is_io & r_q.is_wr;
        end
        else
        begin
            bus_addr = cpu_addr;
            bus_wdata = cpu_wdata;
            bus_memrd = cpu_memrd;
            bus_memwr = cpu_memwr;
            bus_iord = cpu_iord;
            bus_iowr = cpu_iowr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Memory and port decode
    logic rom0_hit, sock1_hit, ram_hit, mem_cyc, io_cyc;

    assign mem_cyc = bus_memrd | bus_memwr;
    assign io_cyc = bus_iord | bus_iowr;

    // Socket 0 beats socket 1 beats RAM when jumpers overlap
    always_comb
    begin
        rom0_hit = bus_addr[15:12] == rom0_b_s;
        rom0_hit = rom0_hit & (rom0_4k_s | ~bus_addr[11]);
        sock1_hit = (bus_addr[15:12] == sock1_b_s) & ~rom0_hit;
        if (sock1_2k_s)
        begin
            sock1_hit = sock1_hit & ~bus_addr[11];
        end
        else
        begin
            sock1_hit = sock1_hit & (bus_addr[11:10] == 2'b00);
        end
        ram_hit = (bus_addr[15:12] == ram_b_s) & (bus_addr[11:10] == 2'b00);
        ram_hit = ram_hit & ~rom0_hit & ~sock1_hit;
    end

    assign rom0_sel = mem_cyc & rom0_hit;
    assign sock1_sel = mem_cyc & sock1_hit;
    assign sock1_we = bus_memwr & sock1_hit & sock1_ram_s;
    assign ram_sel = mem_cyc & ram_hit;

    // Host I/O only ever reaches the status port, so it is kept off
    always_comb
    begin
        port_sel = 16'h0000;
        if (io_cyc && !host_owns && bus_addr[7:4] == LOCAL_PORT_HI)
        begin
            port_sel[bus_addr[3:0]] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // On-board static RAM
    logic [RAM_WIDTH-1:0] ram_mem [RAM_DEPTH];
    logic [RAM_AW-1:0] ram_idx;

    assign ram_idx = bus_addr[RAM_AW-1:0];

    always_ff @(posedge clk_sys)
    begin
        if (bus_memwr && ram_hit)
        begin
            ram_mem[ram_idx] <= bus_wdata;
        end
    end

    // Combinational read keeps a host read to one transfer cycle
    assign bus_rdata = ram_hit ? ram_mem[ram_idx] : ext_rdata;

    always_comb
    begin
        if (cpu_addr[7:0] == LOCAL_STATUS_PORT && cpu_iord)
        begin
            cpu_rdata = r_q.status;
        end
        else
        begin
            cpu_rdata = bus_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer and registers
    logic l_io_wr, h_stat_wr, h_stat_rd;

    assign l_io_wr = cpu_iowr & ~host_owns;
    assign h_stat_wr = xfer & r_q.is_io & r_q.is_wr;
    assign h_stat_rd = xfer & r_q.is_io & ~r_q.is_wr;

    always_comb
    begin
        r_d = r_q;
        r_d.nmi = 1'b0;
        r_d.osc_prev = osc_s;
        r_d.cpu_int = (|rx_s) | tmr_s[0];
        if (osc_s && !r_q.osc_prev)
        begin
            r_d.cpu_clk = ~r_q.cpu_clk;
        end
        if (l_io_wr && cpu_addr[7:0] == LOCAL_STATUS_PORT)
        begin
            r_d.status = cpu_wdata;
        end
        if (l_io_wr && cpu_addr[7:0] == BAUD_PORT_12)
        begin
            r_d.baud[15:8] = cpu_wdata;
        end
        if (l_io_wr && cpu_addr[7:0] == BAUD_PORT_34)
        begin
            r_d.baud[7:0] = cpu_wdata;
        end
        if (h_stat_rd)
        begin
            r_d.hint = 1'b0;
        end
        case (r_q.st)
            ST_IDLE:
            begin
                if (h_strobe && h_hit)
                begin
                    r_d.st = ST_REQ;
                    r_d.is_io = h_io;
                    r_d.is_wr = h_sout_s | h_memw_s;
                    r_d.addr = h_addr_s;
                    r_d.wdata = h_dout_s;
                end
            end
            ST_REQ:
            begin
                if (grant_s)
                begin
                    r_d.st = ST_XFER;
                end
            end
            ST_XFER:
            begin
                r_d.st = ST_HOLD;
                if (r_q.is_io && r_q.is_wr)
                begin
                    // Status byte untouched by the host
                    r_d.nmi = 1'b1;
                    r_d.hint = r_q.hint | hint_en_s;
                end
                else if (r_q.is_io)
                begin
                    r_d.din = r_q.status;
                end
                else if (!r_q.is_wr)
                begin
                    r_d.din = bus_rdata;
                end
            end
            ST_HOLD:
            begin
                // Wait for the host to end the cycle before re-arming
                if (!h_strobe)
                begin
                    r_d.st = ST_IDLE;
                end
            end
            default:
            begin
                r_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (clr)
        begin
            r_q.st <= ST_IDLE;
            r_q.is_io <= 1'b0;
            r_q.is_wr <= 1'b0;
            r_q.addr <= 16'h0000;
            r_q.wdata <= 8'h00;
            r_q.din <= DIN_RESET;
            r_q.status <= STATUS_RESET;
            r_q.baud <= BAUD_RESET;
            r_q.hint <= 1'b0;
            r_q.nmi <= 1'b0;
            r_q.osc_prev <= 1'b0;
            r_q.cpu_clk <= 1'b0;
            r_q.cpu_int <= 1'b0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign local_bus_request = (r_q.st == ST_REQ) | xfer;
    assign host_addr_buf_en = r_q.st != ST_IDLE;
    // Ready also stays low through the one latch cycle after the grant
    assign host_prdy = ~local_bus_request;
    assign host_din_buf_en = host_owns & ~r_q.is_wr
        & (r_q.st == ST_XFER || r_q.st == ST_HOLD);
    assign host_dout_buf_en = host_owns & r_q.is_wr & xfer;
    assign host_din = r_q.din;
    assign host_vi = r_q.hint ? 4'h1 << hint_line_s : 4'h0;
    assign local_nmi = r_q.nmi;
    assign local_int = r_q.cpu_int;
    assign cpu_clk = r_q.cpu_clk;
    // Undivided; jitter of one sample is below baud tolerance
    assign baud_rate_generator_clk = osc_s;
    assign baud_code = r_q.baud;
    assign user_timer_header = tmr_s[3:1];

    ////////////////////////////////////////////////////////////////
    // Assertions
    wait_hold_a: assert property (@(posedge clk_sys) disable iff (clr)
        (r_q.st == ST_REQ || xfer) |-> !host_prdy)
        else $error("host ready high while waiting for grant");

    select_req_a: assert property (@(posedge clk_sys) disable iff (clr)
        (r_q.st == ST_IDLE && h_strobe && h_hit)
        |=> (local_bus_request && host_addr_buf_en))
        else $error("selection did not raise bus request");

    grant_xfer_a: assert property (@(posedge clk_sys) disable iff (clr)
        (r_q.st == ST_REQ && grant_s) |=> (xfer ##1 host_prdy))
        else $error("grant did not release the host");

    mux_route_a: assert property (@(posedge clk_sys) disable iff (clr)
        bus_addr == (grant_s ? r_q.addr : cpu_addr))
        else $error("bus address from wrong owner");

    hint_set_a: assert property (@(posedge clk_sys) disable iff (clr)
        (h_stat_wr && hint_en_s) |=> (r_q.hint && host_vi != 4'h0))
        else $error("host interrupt not raised on status write");

    hint_clear_a: assert property (@(posedge clk_sys) disable iff (clr)
        h_stat_rd |=> !r_q.hint)
        else $error("host interrupt not removed by status read");

    nmi_pulse_a: assert property (@(posedge clk_sys) disable iff (clr)
        h_stat_wr |=> local_nmi ##1 !local_nmi)
        else $error("local nmi not a single pulse");

    status_keep_a: assert property (@(posedge clk_sys) disable iff (clr)
        (h_stat_wr && !l_io_wr) |=> $stable(r_q.status))
        else $error("host write changed status byte");

    status_local_a: assert property (@(posedge clk_sys) disable iff (clr)
        (l_io_wr && cpu_addr[7:0] == LOCAL_STATUS_PORT)
        |=> r_q.status == $past(cpu_wdata))
        else $error("local status write lost");

    clk_div_a: assert property (@(posedge clk_sys) disable iff (clr)
        (osc_s && !r_q.osc_prev) |=> cpu_clk != $past(cpu_clk))
        else $error("processor clock not toggled on oscillator edge");

    poc_idle_a: assert property (@(posedge clk_sys)
        poc_s |=> (r_q.st == ST_IDLE && !r_q.hint && host_prdy))
        else $error("power-on clear left board busy");

    port_onehot_a: assert property (@(posedge clk_sys) disable iff (clr)
        (cpu_iowr && !grant_s && cpu_addr[7:4] == LOCAL_PORT_HI)
        |-> port_sel == 16'h0001 << cpu_addr[3:0])
        else $error("port select not one-hot on address");
endmodule

// File: tb/hbs_host_model.sv
// Host processor model driving the shared host bus of the bridge.
// Assumes the bench calls access() and the bridge answers on host_prdy.
`timescale 1ns/1ns
module hbs_host_model
(
    input wire logic clk_sys,
    input wire logic host_prdy,
    input wire logic [7:0] host_din,
    output logic [15:0] host_addr,
    output logic [7:0] host_dout,
    output logic host_sout,
    output logic host_sinp,
    output logic host_memr,
    output logic host_memw
);
    initial
    begin
        host_addr = 16'h0000;
        host_dout = 8'h00;
        {host_sout, host_sinp, host_memr, host_memw} = 4'h0;
    end

    ////////////////////////////////////////////////////////////////
    // Kind: 0 mem read, 1 mem write, 2 io read, 3 io write
    task automatic access(input logic [1:0] kind, input logic [15:0] a,
        input logic [7:0] d, output logic [7:0] rd, output int waits);
        int n;
        n = 0;
        waits = 0;
        @(posedge clk_sys);
        #1;
        host_addr = a;
        host_dout = kind[0] ? d : ~d;
        host_sout = (kind == 2'h3);
        host_sinp = (kind == 2'h2);
        host_memr = (kind == 2'h0);
        host_memw = (kind == 2'h1);
        // A miss never pulls ready low, so give up after a few cycles
        while (host_prdy === 1'b1 && n < 8)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while (host_prdy !== 1'b1 && waits < 300)
        begin
            @(posedge clk_sys);
            #1;
            waits++;
        end
        rd = host_din;
        {host_sout, host_sinp, host_memr, host_memw} = 4'h0;
        // Released lines no longer hold the last value
        host_addr = ~a;
        host_dout = ~host_dout;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench of the host bus share bridge.
// Assumes hbs_pkg and the host model; the bench plays the local processor.
`timescale 1ns/1ns
module testbench;
    import hbs_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, host_poc = 1'b0, osc_in = 1'b0;
    logic [15:0] host_addr, bus_addr, port_sel, baud_code, cpu_addr = 16'h0000;
    logic [7:0] host_dout, host_din, cpu_rdata, bus_wdata, rd, crd, cpu_wdata = 8'h00;
    logic host_sout, host_sinp, host_memr, host_memw, host_prdy, host_addr_buf_en;
    logic host_din_buf_en, host_dout_buf_en, local_bus_request, local_nmi, local_int;
    logic cpu_clk, baud_rate_generator_clk, bus_memrd, bus_memwr, bus_iord, bus_iowr;
    logic rom0_sel, sock1_sel, sock1_we, ram_sel, cc, bc, saw_req;
    logic [3:0] host_vi, board_num = 4'h3, host_win_base = 4'h8, rom0_base = 4'h0;
    logic [3:0] sock1_base = 4'h2, ram_base = 4'h1, serial_rx_irq = 4'h0;
    logic [3:0] counter_timer_ch = 4'h0;
    logic [2:0] user_timer_header;
    logic [1:0] hint_line = 2'h2;
    logic hint_enable = 1'b1, rom0_is_4k = 1'b0, sock1_is_2k = 1'b0, sock1_is_ram = 1'b1;
    logic local_bus_grant = 1'b0, cpu_memrd = 1'b0, cpu_memwr = 1'b0;
    logic cpu_iord = 1'b0, cpu_iowr = 1'b0;
    logic [7:0] ext_rdata = 8'h3c;
    logic [23:0] wr_seen;
    logic [1:0] buf_seen;
    int n_fail = 0, n_tests = 0, gdelay = 0, gcnt = 0, n_nmi = 0, n_cpu, n_brg, w;
    // Row: address, mem read, io read, {rom0, sock1, ram, port_sel}
    logic [36:0] rows [11] = '{
        {16'h0000, 2'b10, 19'h40000}, {16'h07ff, 2'b10, 19'h40000},
        {16'h0800, 2'b10, 19'h00000}, {16'h1000, 2'b10, 19'h10000},
        {16'h13ff, 2'b10, 19'h10000}, {16'h2000, 2'b10, 19'h20000},
        {16'h23ff, 2'b10, 19'h20000}, {16'h2400, 2'b10, 19'h00000},
        {16'h0003, 2'b01, 19'h00008}, {16'h000f, 2'b01, 19'h08000},
        {16'h0013, 2'b01, 19'h00000}};

    hbs_bridge hbs_bridge_i (.*);
    hbs_host_model hbs_host_model_i (.*);

    always #25 clk_sys = ~clk_sys;
    // Near 4.9 MHz, free of any phase tie to clk_sys
    always #102 osc_in = ~osc_in;

    ////////////////////////////////////////////////////////////////
    // Local processor grant, given gdelay cycles after the request
    always @(posedge clk_sys)
        if (local_bus_request !== 1'b1)
        begin
            gcnt <= 0;
            local_bus_grant <= #1 1'b0;
        end
        else if (gcnt >= gdelay)
            local_bus_grant <= #1 1'b1;
        else
            gcnt <= gcnt + 1;

    always @(posedge clk_sys)
    begin
        if (local_nmi === 1'b1) n_nmi++;
        if (local_bus_request === 1'b1 && host_addr_buf_en === 1'b1) saw_req = 1'b1;
        if (bus_memwr === 1'b1) wr_seen = {bus_addr, bus_wdata};
        if (bus_memwr === 1'b1 || bus_memrd === 1'b1)
            buf_seen = {host_dout_buf_en, host_din_buf_en};
        if (cpu_clk === 1'b1 && cc === 1'b0) n_cpu++;
        if (baud_rate_generator_clk === 1'b1 && bc === 1'b0) n_brg++;
        cc = cpu_clk;
        bc = baud_rate_generator_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic hacc(input logic [1:0] kind, input logic [15:0] a, input logic [7:0] d);
        hbs_host_model_i.access(kind, a, d, rd, w);
        if (w >= 300)
        begin
            n_fail++;
            give_verdict();
        end
    endtask

    task automatic cpu_io(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_iowr = wr;
        cpu_iord = !wr;
        @(posedge clk_sys);
        crd = cpu_rdata;
        #1;
        cpu_iowr = 1'b0;
        cpu_iord = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        chk("ready", host_prdy, 1);
        chk("request", local_bus_request, 0);
        chk("vectors", host_vi, 0);
        chk("baud", baud_code, BAUD_RESET);
        $display("test reset done");
        foreach (rows[i])
        begin
            @(posedge clk_sys);
            #1;
            {cpu_addr, cpu_memrd, cpu_iord} = rows[i][36:19];
            #5;
            chk("decode", {rom0_sel, sock1_sel, ram_sel, port_sel}, rows[i][18:0]);
        end
        cpu_memrd = 1'b0;
        cpu_iord = 1'b0;
        rom0_is_4k = 1'b1;
        sock1_is_2k = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        {cpu_addr, cpu_memrd} = {16'h0800, 1'b1};
        #5;
        chk("rom0 4k", rom0_sel, 1);
        @(posedge clk_sys);
        #1;
        cpu_addr = 16'h2400;
        #5;
        chk("sock1 2k", sock1_sel, 1);
        @(posedge clk_sys);
        #1;
        {cpu_addr, cpu_wdata, cpu_memrd, cpu_memwr} = {16'h1005, 8'h66, 1'b0, 1'b1};
        #5;
        chk("ram write", {ram_sel, sock1_we}, 2'b10);
        @(posedge clk_sys);
        #1;
        {cpu_memwr, cpu_memrd} = 2'b01;
        #5;
        chk("ram read", cpu_rdata, 8'h66);
        @(posedge clk_sys);
        #1;
        {cpu_addr, cpu_memrd, cpu_memwr} = {16'h2000, 1'b0, 1'b1};
        #5;
        chk("sock1 write", sock1_we, 1);
        @(posedge clk_sys);
        #1;
        cpu_memwr = 1'b0;
        $display("test decode done");
        cpu_io(1'b1, 16'h000f, 8'ha5);
        cpu_io(1'b1, 16'h000d, 8'h12);
        cpu_io(1'b1, 16'h000e, 8'h34);
        cpu_io(1'b0, 16'h000f, 8'h00);
        chk("local status", crd, 8'ha5);
        chk("baud", baud_code, 16'h1234);
        $display("test local ports done");
        gdelay = 12;
        saw_req = 1'b0;
        hacc(2'h2, 16'h00f3, 8'h00);
        chk("host status", rd, 8'ha5);
        chk("wait", w > 12, 1);
        chk("request", saw_req, 1);
        gdelay = 0;
        n_nmi = 0;
        hacc(2'h3, 16'h00f3, 8'h5a);
        chk("nmi", n_nmi, 1);
        chk("vectors", host_vi, 4'h4);
        cpu_io(1'b0, 16'h000f, 8'h00);
        chk("status kept", crd, 8'ha5);
        hacc(2'h2, 16'h00f3, 8'h00);
        chk("vectors", host_vi, 0);
        hint_enable = 1'b0;
        hacc(2'h3, 16'h00f3, 8'h11);
        chk("vectors", host_vi, 0);
        chk("nmi", n_nmi, 2);
        hint_enable = 1'b1;
        hacc(2'h3, 16'h00e3, 8'h22);
        chk("miss wait", w, 0);
        hacc(2'h3, 16'h00f4, 8'h22);
        chk("miss wait", w, 0);
        chk("nmi", n_nmi, 2);
        $display("test host status done");
        hacc(2'h1, 16'h8005, 8'h77);
        chk("host write", wr_seen, 24'h800577);
        chk("buffers", buf_seen, 2'b10);
        hacc(2'h0, 16'h8010, 8'h00);
        chk("host read", rd, 8'h3c);
        chk("buffers", buf_seen, 2'b01);
        $display("test host memory done");
        n_cpu = 0;
        n_brg = 0;
        repeat (400) @(posedge clk_sys);
        chk("osc rate", n_brg >= 96 && n_brg <= 100, 1);
        chk("cpu clock", n_brg >= 2 * n_cpu - 2 && n_brg <= 2 * n_cpu + 2, 1);
        counter_timer_ch = 4'hb;
        repeat (5) @(posedge clk_sys);
        chk("user timers", user_timer_header, 3'h5);
        chk("tick int", local_int, 1);
        counter_timer_ch = 4'h0;
        serial_rx_irq = 4'h4;
        repeat (5) @(posedge clk_sys);
        chk("rx int", local_int, 1);
        serial_rx_irq = 4'h0;
        repeat (5) @(posedge clk_sys);
        chk("rx int", local_int, 0);
        $display("test clocks and ints done");
        gdelay = 40;
        fork
            hacc(2'h2, 16'h00f3, 8'h00);
            begin
                repeat (8) @(posedge clk_sys);
                #1;
                host_poc = 1'b1;
                repeat (3) @(posedge clk_sys);
                #1;
                host_poc = 1'b0;
                repeat (4) @(posedge clk_sys);
                chk("ready", host_prdy, 1);
                chk("request", local_bus_request, 0);
            end
        join
        $display("test power-on clear done");
        give_verdict();
    end
endmodule
